// [src/paired_timer_control.v]
// Function
// R1: The two-bit divide select divides the count source by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// R2: A write to a control word while its run bit is set clears that timer's prescale counter.
// R3: With the join bit set the even timer and its odd partner count as one 32-bit counter.
// R4: With the join bit clear the even and odd timers count as two separate 16-bit counters.
// R5: While joined, only the even control word governs the counter and the odd word is ignored.
// R6: Source select 1 takes the source named by the extended field, 0 takes the internal clock.
// R7: Control bits 2 and 0 always read zero and ignore writes.
// R8: The second pair has its own join bit at the same position with identical behaviour.
// R9: Software must route a chosen external timer input to a remappable pin before using it.
// R10: Each completed prescale group advances the count by one while the run bit is set.
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "paired_timer_consts.vh"

module paired_timer_control #(
    parameter PRESCALE_W = 8
) (
    input  wire         clk,
    input  wire         srst,
    input  wire         wb_cyc_i,
    input  wire         wb_stb_i,
    input  wire         wb_we_i,
    input  wire [7:0]   wb_adr_i,
    input  wire [3:0]   wb_sel_i,
    input  wire [31:0]  wb_dat_i,
    output reg  [31:0]  wb_dat_o,
    output reg          wb_ack_o,
    input  wire         secondary_osc_in,
    input  wire         lowpower_osc_in,
    input  wire         shared_external_count_input,
    input  wire [3:0]   per_timer_external_input,
    output reg  [3:0]   timer_advance_out
);

    // Bus request handshake; ack drops the cycle after it is given
    // A master that keeps stb up after ack gets no second answer in that cycle;
    // the request is taken again on the following edge
    wire        req_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr_go  = req_go & wb_we_i;
    wire        adr_in_map = (wb_adr_i[7:5] == 3'b000);

    // Edge detection on external count sources (inputs are synchronous)
    // Previous-value flops reset low to match the idle level, so no false edge follows reset
    // An external source must stay high and low for a full clock each to be seen
    reg         secondary_prev_reg;
    reg         lowpower_prev_reg;
    reg         shared_prev_reg;
    reg  [3:0]  per_timer_prev_reg;
    wire        secondary_rise = secondary_osc_in & ~secondary_prev_reg;
    wire        lowpower_rise  = lowpower_osc_in & ~lowpower_prev_reg;
    wire        shared_rise    = shared_external_count_input & ~shared_prev_reg;
    wire [3:0]  per_timer_rise = per_timer_external_input & ~per_timer_prev_reg;

    always @(posedge clk) begin
        if (srst) begin
            secondary_prev_reg <= 1'b0;
            lowpower_prev_reg  <= 1'b0;
            shared_prev_reg    <= 1'b0;
            per_timer_prev_reg <= 4'h0;
        end else begin
            secondary_prev_reg <= secondary_osc_in;
            lowpower_prev_reg  <= lowpower_osc_in;
            shared_prev_reg    <= shared_external_count_input;
            per_timer_prev_reg <= per_timer_external_input;
        end
    end

    // Byte-lane merge of a write into a 16-bit register under a bit mask
    // Masking after the merge keeps unimplemented bits at zero whatever is written
    function [15:0] lane_merge;
        input [15:0] old_val;
        input [15:0] new_val;
        input [1:0]  sel;
        input [15:0] mask;
        reg   [15:0] merged;
        begin
            merged = old_val;
            if (sel[0]) begin
                merged[7:0] = new_val[7:0];
            end
            if (sel[1]) begin
                merged[15:8] = new_val[15:8];
            end
            lane_merge = merged & mask;
        end
    endfunction

    // Count tick for one timer; the peripheral clock itself is the Fosc/2 source
    // The internal source ticks every clock, so divide by one counts once per cycle
    function source_tick;
        input       use_ext;
        input [1:0] ext_sel;
        input       sec_rise;
        input       own_rise;
        input       lpo_rise;
        input       shr_rise;
        begin
            if (!use_ext) begin
                source_tick = 1'b1;
            end else begin
                case (ext_sel)
                    `EXT_SECONDARY_OSC: source_tick = sec_rise;
                    `EXT_PER_TIMER:     source_tick = own_rise;
                    `EXT_LOWPOWER_OSC:  source_tick = lpo_rise;
                    default:            source_tick = shr_rise;
                endcase
            end
        end
    endfunction

    // Flattened views of per-pair state for the read mux and the advance output
    // Pair p occupies bits 16p+15 down to 16p of each 32-bit bus, and bits 2p+1 and 2p of advance_all
    wire [31:0] ctrl_even_all;
    wire [31:0] ctrl_odd_all;
    wire [31:0] count_even_all;
    wire [31:0] count_odd_all;
    wire [3:0]  advance_all;

    // Both pairs share the external edge detectors; only the per-timer input is private
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : pair_g
            reg  [15:0] ctrl_even_reg;
            reg  [15:0] ctrl_odd_reg;
            reg  [15:0] count_even_reg;
            reg  [15:0] count_odd_reg;
            wire        pair_hit;
            wire        wr_ctrl_even;
            wire        wr_ctrl_odd;
            wire        wr_count_even;
            wire        wr_count_odd;
            wire        joined;
            wire        even_run;
            wire        odd_run;
            wire        even_tick;
            wire        odd_tick;
            wire        even_term;
            wire        odd_term;
            wire        even_adv;
            wire        odd_adv;
            wire        even_wrap;

            // Decode; the pair select bit picks pair 0 or pair 1
            // Address bit 4 splits control words from counts, bit 2 even from odd
            assign pair_hit = adr_in_map &
                              ((p == 0) ? ~wb_adr_i[`ADR_PAIR_BIT] : wb_adr_i[`ADR_PAIR_BIT]);
            assign wr_ctrl_even  = wr_go & pair_hit & ~wb_adr_i[`ADR_COUNT_BIT] &
                                   ~wb_adr_i[`ADR_PARITY_BIT];
            assign wr_ctrl_odd   = wr_go & pair_hit & ~wb_adr_i[`ADR_COUNT_BIT] &
                                   wb_adr_i[`ADR_PARITY_BIT];
            assign wr_count_even = wr_go & pair_hit & wb_adr_i[`ADR_COUNT_BIT] &
                                   ~wb_adr_i[`ADR_PARITY_BIT];
            assign wr_count_odd  = wr_go & pair_hit & wb_adr_i[`ADR_COUNT_BIT] &
                                   wb_adr_i[`ADR_PARITY_BIT];

            // Join bit of this pair lives in its even control word
            assign joined   = ctrl_even_reg[`BIT_JOIN]; // R3 R4 R8
            assign even_run = ctrl_even_reg[`BIT_RUN];
            // Odd control is dead while joined
            // The odd run bit is masked rather than cleared so software reads what it wrote
            assign odd_run  = ctrl_odd_reg[`BIT_RUN] & ~joined; // R5 R8

            assign even_tick = source_tick(ctrl_even_reg[`BIT_SRC],
                                           ctrl_even_reg[`BIT_EXT_HI:`BIT_EXT_LO],
                                           secondary_rise, per_timer_rise[2*p],
                                           lowpower_rise, shared_rise); // R6
            assign odd_tick  = source_tick(ctrl_odd_reg[`BIT_SRC],
                                           ctrl_odd_reg[`BIT_EXT_HI:`BIT_EXT_LO],
                                           secondary_rise, per_timer_rise[2*p+1],
                                           lowpower_rise, shared_rise); // R6

            // Prescalers are cleared by a control write made while running
            // Clear and terminal in the same cycle: the group that just finished still counts
            // The odd clear follows its own stored run bit even while joined; it has no effect
            timer_prescaler #(
                .W          (PRESCALE_W)
            ) even_div (
                .clk        (clk),
                .srst       (srst),
                .clear      (wr_ctrl_even & even_run), // R2
                .enable     (even_run),
                .divide_sel (ctrl_even_reg[`BIT_DIV_HI:`BIT_DIV_LO]),
                .src_tick   (even_tick),
                .terminal   (even_term)
            );

            timer_prescaler #(
                .W          (PRESCALE_W)
            ) odd_div (
                .clk        (clk),
                .srst       (srst),
                .clear      (wr_ctrl_odd & ctrl_odd_reg[`BIT_RUN]), // R2
                .enable     (odd_run),
                .divide_sel (ctrl_odd_reg[`BIT_DIV_HI:`BIT_DIV_LO]),
                .src_tick   (odd_tick),
                .terminal   (odd_term)
            );

            assign even_adv  = even_term; // R10
            assign even_wrap = even_adv & (count_even_reg == 16'hffff);
            // Joined: odd half steps on the low half's carry
            // No latch of the high half: a carry may land between reading low and high,
            // so software must re-read to get a consistent 32-bit value
            assign odd_adv   = joined ? even_wrap : odd_term; // R3 R4

            // Control words; unimplemented bits never store
            // The two bytes are separate lanes, so a one-byte write leaves
            // the other byte of the word untouched
            always @(posedge clk) begin
                if (srst) begin
                    ctrl_even_reg <= `CTRL_RESET;
                    ctrl_odd_reg  <= `CTRL_RESET;
                end else begin
                    if (wr_ctrl_even) begin
                        ctrl_even_reg <= lane_merge(ctrl_even_reg, wb_dat_i[15:0],
                                                    wb_sel_i[1:0], `CTRL_EVEN_MASK); // R7
                    end
                    if (wr_ctrl_odd) begin
                        ctrl_odd_reg <= lane_merge(ctrl_odd_reg, wb_dat_i[15:0],
                                                   wb_sel_i[1:0], `CTRL_ODD_MASK); // R7
                    end
                end
            end

            // Counters; a software write wins over a same-cycle advance
            // Counts stay writable while running; such a write discards the pending advance
            always @(posedge clk) begin
                if (srst) begin
                    count_even_reg <= `COUNT_RESET;
                    count_odd_reg  <= `COUNT_RESET;
                end else begin
                    if (wr_count_even) begin
                        count_even_reg <= lane_merge(count_even_reg, wb_dat_i[15:0],
                                                     wb_sel_i[1:0], 16'hffff);
                    end else if (even_adv) begin
                        count_even_reg <= count_even_reg + 16'h0001; // R10
                    end
                    if (wr_count_odd) begin
                        count_odd_reg <= lane_merge(count_odd_reg, wb_dat_i[15:0],
                                                    wb_sel_i[1:0], 16'hffff);
                    end else if (odd_adv) begin
                        count_odd_reg <= count_odd_reg + 16'h0001; // R3 R4
                    end
                end
            end

            assign ctrl_even_all[16*p +: 16]  = ctrl_even_reg;
            assign ctrl_odd_all[16*p +: 16]   = ctrl_odd_reg;
            assign count_even_all[16*p +: 16] = count_even_reg;
            assign count_odd_all[16*p +: 16]  = count_odd_reg;
            assign advance_all[2*p]           = even_adv;
            assign advance_all[2*p+1]         = odd_adv;
        end
    endgenerate

    // Read mux; unmapped words read zero
    // Address bits 1:0 are ignored, so any byte address hits its word
    reg  [15:0] rd_data;
    always @* begin
        case ({wb_adr_i[7:2], 2'b00})
            `OFS_CTRL_EVEN0:  rd_data = ctrl_even_all[15:0];
            `OFS_CTRL_ODD0:   rd_data = ctrl_odd_all[15:0];
            `OFS_CTRL_EVEN1:  rd_data = ctrl_even_all[31:16];
            `OFS_CTRL_ODD1:   rd_data = ctrl_odd_all[31:16];
            `OFS_COUNT_EVEN0: rd_data = count_even_all[15:0];
            `OFS_COUNT_ODD0:  rd_data = count_odd_all[15:0];
            `OFS_COUNT_EVEN1: rd_data = count_even_all[31:16];
            `OFS_COUNT_ODD1:  rd_data = count_odd_all[31:16];
            default:          rd_data = 16'h0000;
        endcase
    end

    // Registered bus answer: one wait state, data valid with ack
    // Read data is zero outside the ack cycle so stale values never linger on the bus
    // Writes get a zero data word as well; the upper half of the bus is always zero
    always @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req_go;
            if (req_go && !wb_we_i) begin
                wb_dat_o <= {16'h0000, rd_data};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // Advance pulses brought out through a flop for observation
    // The pulse rises on the same edge as the count update, which keeps the output glitch free
    always @(posedge clk) begin
        if (srst) begin
            timer_advance_out <= 4'h0;
        end else begin
            timer_advance_out <= advance_all;
        end
    end

endmodule

`default_nettype wire

// [src/paired_timer_consts.vh]
`ifndef PAIRED_TIMER_CONSTS_VH
`define PAIRED_TIMER_CONSTS_VH

// Word offsets on the register bus (byte addresses)
`define OFS_CTRL_EVEN0      8'h00
`define OFS_CTRL_ODD0       8'h04
`define OFS_CTRL_EVEN1      8'h08
`define OFS_CTRL_ODD1       8'h0c
`define OFS_COUNT_EVEN0     8'h10
`define OFS_COUNT_ODD0      8'h14
`define OFS_COUNT_EVEN1     8'h18
`define OFS_COUNT_ODD1      8'h1c

// Address decode bit positions
`define ADR_PARITY_BIT      2
`define ADR_PAIR_BIT        3
`define ADR_COUNT_BIT       4

// Control word field positions
`define BIT_RUN             15
`define BIT_EXT_HI          9
`define BIT_EXT_LO          8
`define BIT_DIV_HI          5
`define BIT_DIV_LO          4
`define BIT_JOIN            3
`define BIT_SRC             1

// Writable and readable bits of the control words
`define CTRL_EVEN_MASK      16'h833a
`define CTRL_ODD_MASK       16'h8332

// Reset values
`define CTRL_RESET          16'h0000
`define COUNT_RESET         16'h0000
`define PRESCALE_RESET      8'h00

// Prescale terminal counts (divide ratio minus one)
`define DIV_1_LIMIT         8'h00
`define DIV_8_LIMIT         8'h07
`define DIV_64_LIMIT        8'h3f
`define DIV_256_LIMIT       8'hff

// Divide select codes
`define DIV_CODE_1          2'b00
`define DIV_CODE_8          2'b01
`define DIV_CODE_64         2'b10
`define DIV_CODE_256        2'b11

// Extended source codes
`define EXT_SECONDARY_OSC   2'b00
`define EXT_PER_TIMER       2'b01
`define EXT_LOWPOWER_OSC    2'b10
`define EXT_SHARED          2'b11

`endif

// [src/timer_prescaler.v]
`timescale 1ns/1ps
`default_nettype none
`include "paired_timer_consts.vh"

module timer_prescaler #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         srst,
    input  wire         clear,
    input  wire         enable,
    input  wire [1:0]   divide_sel,
    input  wire         src_tick,
    output wire         terminal
);

    reg  [W-1:0] count_reg;
    reg  [W-1:0] count_next;
    reg  [W-1:0] limit;

    // Terminal count for each divide code
    always @* begin
        case (divide_sel)
            `DIV_CODE_256: limit = `DIV_256_LIMIT; // R1
            `DIV_CODE_64:  limit = `DIV_64_LIMIT;  // R1
            `DIV_CODE_8:   limit = `DIV_8_LIMIT;   // R1
            default:       limit = `DIV_1_LIMIT;   // R1
        endcase
    end

    // One pulse per completed group of source ticks
    assign terminal = enable & src_tick & (count_reg == limit); // R10

    always @* begin
        count_next = count_reg;
        if (enable && src_tick) begin
            if (terminal) begin
                count_next = `PRESCALE_RESET;
            end else begin
                count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Clear has priority over counting so a rewrite restarts the division
    always @(posedge clk) begin
        if (srst || clear) begin
            count_reg <= `PRESCALE_RESET; // R2
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

`default_nettype wire

// [test/paired_timer_control_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// Bus and pulse checks on the pins of the timer pair control block
module paired_timer_control_checker #(
    parameter PRESCALE_W = 8
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [3:0]  timer_advance_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Bus handshake: fixed one-cycle answer, single-cycle ack and data
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_IDLE_DATA: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack cycle");
    AST_UNMAPPED: assert property (wb_ack_o && wb_adr_i[7:5] != 3'h0 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    AST_CTRL_GAPS: assert property (
        wb_ack_o && wb_adr_i[7:4] == 4'h0 |-> wb_dat_o[2] == 1'b0 && wb_dat_o[0] == 1'b0)
        else $error("unimplemented control bits read nonzero");
    AST_ODD_JOIN: assert property (
        wb_ack_o && wb_adr_i[7:4] == 4'h0 && wb_adr_i[2] |-> wb_dat_o[3] == 1'b0)
        else $error("odd control word shows a join bit");
    AST_RESET_QUIET: assert property (
        $past(srst) |-> timer_advance_out == 4'h0 && !wb_ack_o)
        else $error("activity right after reset");
    // A stop written to the first timer ends its advances at once
    AST_STOP_NO_ADV: assert property (
        wb_ack_o && wb_we_i && wb_sel_i[1] && wb_adr_i == 8'h00 && !wb_dat_i[15]
        |=> !timer_advance_out[0] [*4])
        else $error("timer advanced after stop");
endmodule

bind paired_timer_control paired_timer_control_checker #(.PRESCALE_W(PRESCALE_W)) chk_i (
    .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_advance_out(timer_advance_out));
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// Register-level bench for the timer pair control block
module tb;
    logic        clk;
    logic        srst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [6:0]  src;
    logic [3:0]  adv;
    logic [15:0] q;
    logic [7:0]  b;
    int          num_errors;
    int          cmp_count;
    int          ticks;
    int          pulses;
    int          p0;
    int          p1;
    int          opulses;
    int          i;
    int          n;

    paired_timer_control paired_timer_control_i (
        .clk                         (clk),
        .srst                        (srst),
        .wb_cyc_i                    (cyc),
        .wb_stb_i                    (stb),
        .wb_we_i                     (we),
        .wb_adr_i                    (adr),
        .wb_sel_i                    (sel),
        .wb_dat_i                    (wdat),
        .wb_dat_o                    (rdat),
        .wb_ack_o                    (ack),
        .secondary_osc_in            (src[0]),
        .lowpower_osc_in             (src[2]),
        .shared_external_count_input (src[3]),
        .per_timer_external_input    ({src[6:4], src[1]}),
        .timer_advance_out           (adv)
    );

    // 50 ns bench clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Hang guard and tally of first-timer advance pulses
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (adv[0] === 1'b1)
            pulses <= pulses + 1;
        if (adv[1] === 1'b1 || adv[3] === 1'b1)
            opulses <= opulses + 1;
        if (ticks == 5000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One classic cycle; held until ack is sampled, data taken at that edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [15:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
            k = k + 1;
        end while (ack !== 1'b1 && k < 20);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        check({15'h0000, ack}, 16'h0001);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, 4'h3, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        bus(1'b0, a, 4'hf, 16'h0000);
        check(q, exp);
    endtask

    // Source k rises m times, two cycles high and two low each
    task automatic pulse(input int k, input int m);
        repeat (m) begin
            @(posedge clk);
            src[k] <= 1'b1;
            repeat (2) @(posedge clk);
            src[k] <= 1'b0;
            @(posedge clk);
        end
    endtask

    initial begin
        {cyc, stb, we, adr, sel, wdat, src} = '0;
        srst = 1'b1;
        num_errors = 0;
        cmp_count = 0;
        ticks = 0;
        pulses = 0;
        opulses = 0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        // Unmapped write must not alias; all places zero, unmapped too
        wr(8'h20, 16'hffff);
        for (i = 0; i < 9; i++)
            rd(8'(i * 4), 16'h0000);
        // Unimplemented control bits; odd words lack the join bit
        for (i = 0; i < 4; i++) begin
            wr(8'(i * 4), 16'h7fff);
            rd(8'(i * 4), i[0] ? 16'h0332 : 16'h033a);
            wr(8'(i * 4), 16'h0000);
        end
        bus(1'b1, 8'h00, 4'h0, 16'h7fff);
        rd(8'h00, 16'h0000);
        // Every divide code on the internal clock, run window ~4.5 periods
        for (i = 0; i < 4; i++) begin
            n = (i == 3) ? 256 : (1 << (3 * i));
            wr(8'h10, 16'h0000);
            p0 = pulses;
            wr(8'h00, 16'h8000 | 16'(i << 4));
            repeat (4 * n + n / 2 - 3) @(posedge clk);
            wr(8'h00, 16'h0000);
            bus(1'b0, 8'h10, 4'hf, 16'h0000);
            check({15'h0, q >= (4 * n + n / 2 - 1) / n && q <= (4 * n + n / 2) / n}, 16'h1);
            check(q, 16'(pulses - p0));
        end
        // Rewrite while running restarts the divide-by-8 group
        wr(8'h10, 16'h0000);
        wr(8'h00, 16'h8010);
        repeat (10) @(posedge clk);
        wr(8'h00, 16'h8010);
        repeat (10) @(posedge clk);
        wr(8'h00, 16'h0000);
        rd(8'h10, 16'h0002);
        // Each extended source code counts only its own input, not clk
        for (i = 0; i < 4; i++) begin
            wr(8'h10, 16'h0000);
            wr(8'h00, 16'h8002 | 16'(i << 8));
            pulse((i + 1) % 4, 3);
            pulse(i, 5);
            wr(8'h00, 16'h0000);
            rd(8'h10, 16'h0005);
        end
        // Both pairs, separate then joined; running odd word is ignored
        for (i = 0; i < 4; i++) begin
            b = 8'((i / 2) * 8);
            wr(b, i[0] ? 16'h0008 : 16'h0000);
            wr(b + 8'h04, i[0] ? 16'h8000 : 16'h0000);
            wr(b + 8'h10, 16'hfffe);
            wr(b + 8'h14, 16'h0000);
            p1 = opulses;
            wr(b, i[0] ? 16'h8008 : 16'h8000);
            repeat (3) @(posedge clk);
            wr(b, i[0] ? 16'h0008 : 16'h0000);
            rd(b + 8'h14, i[0] ? 16'h0001 : 16'h0000);
            check(16'(opulses - p1), i[0] ? 16'h0001 : 16'h0000);
        end
        complete_run();
    end
endmodule
`default_nettype wire
